// file: clock_mode_pkg.sv
// Constants and types shared by the system clock mode control block
package clock_mode_pkg;
    // Register bus
    localparam int AXI_ADDR_W = 4;
    localparam logic [AXI_ADDR_W-1:0] CTL_OFFS = 4'h0;
    localparam logic [AXI_ADDR_W-1:0] STAT_OFFS = 4'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CTL_W = 16;
    localparam int BYTE_W = 8;
    localparam int CTL_LANES = 2;

    // Field positions of clock_control_reg
    localparam int CTL_STOP_XTAL = 0;
    localparam int CTL_VCO_HALT_CTL = 1;
    localparam int CTL_SYS_SEL = 2;
    localparam int CTL_PLL_SEL_LO = 3;
    localparam int CTL_WAKE_SRC_LO = 5;
    localparam int CTL_WAKE_POL = 7;
    localparam int CTL_DIV_LO = 8;
    localparam int DIV_W = 8;
    localparam int WAKE_SRC_N = 4;

    // Default: direct input, both oscillators running, divisor 1
    localparam logic [CTL_W-1:0] CTL_RESET = 16'h0100;

    // Status register bit positions
    localparam int STAT_CUR_SEL = 0;
    localparam int STAT_SWITCHING = 1;
    localparam int STAT_SLEEP = 2;
    localparam int STAT_SETTLED = 3;
    localparam int STAT_DIV_ERR = 4;

    // PLL arithmetic
    localparam int VCO_MULT_SHIFT = 2;
    localparam int VCO_MULT_W = DIV_W + VCO_MULT_SHIFT;
    localparam logic [DIV_W-1:0] DIV_MIN = 8'h01;
    localparam logic [DIV_W-1:0] DIV_MAX = 8'h9c;

    // PLL settling time
    localparam int CLK_HZ = 100_000_000;
    localparam int PLL_SETTLE_MS = 10;
    localparam int PLL_SETTLE_CYC_DEF = PLL_SETTLE_MS * (CLK_HZ / 1000);
    localparam int SETTLE_W = 20;

    typedef enum logic [1:0] {
        PLL_OUT_VCO,
        PLL_OUT_DIV2,
        PLL_OUT_DIV4,
        PLL_OUT_XTAL_X2
    } pll_out_sel_t;

    typedef enum logic [1:0] {
        SW_RUN,
        SW_OFF,
        SW_ON,
        SW_SLEEP
    } sw_state_t;
endpackage : clock_mode_pkg

// file: system_clock_mode_control.sv
// System clock source selection, oscillator control and sleep wake-up
// Behaviour
// - Software sets clock mode anytime via register
// - Reset and wake clear source select
// - Default leaves crystal and VCO running
// - External direct: select 0, both oscillators stopped
// - Crystal direct: crystal runs, select 0
// - PLL mode: crystal feeds PLL, PLL clocks core
// - VCO runs at four times divisor times input
// - PLL output select offers four choices
// - All three controls set enters deep sleep
// - Chosen trigger at set polarity wakes, restarts
module system_clock_mode_control
    import clock_mode_pkg::*;
#(
    parameter int PLL_SETTLE_CYC = PLL_SETTLE_CYC_DEF
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [AXI_ADDR_W-1:0] i_s_axi_awaddr,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output logic [1:0] o_s_axi_bresp,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [AXI_ADDR_W-1:0] i_s_axi_araddr,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    input wire logic i_clock_input_pin,
    input wire logic i_vco_clk,
    input wire logic i_xtal_x2_clk,
    input wire logic [WAKE_SRC_N-1:0] i_wake_src,
    output logic o_core_clk,
    output logic o_xtal_run,
    output logic o_vco_run,
    output logic o_pll_feed_xtal,
    output logic [VCO_MULT_W-1:0] o_vco_mult,
    output logic [1:0] o_pll_out_sel,
    output logic o_wake_reset,
    output logic o_clk_switching
);
    typedef struct packed {
        logic [CTL_W-1:0] ctl;
        logic aw_got;
        logic [AXI_ADDR_W-1:0] awaddr;
        logic w_got;
        logic [CTL_W-1:0] wdata;
        logic [CTL_LANES-1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        sw_state_t st;
        logic cur_sel;
        logic gated;
        logic core_clk;
        logic pin_q;
        logic vco_q;
        logic x2_q;
        logic div2;
        logic div2_q;
        logic div4;
        logic wake_q;
        logic wake_rst;
        logic [SETTLE_W-1:0] settle_cnt;
        logic settled;
    } state_t;

    localparam state_t STATE_RST = '{ctl: CTL_RESET, st: SW_RUN, default: '0};

    state_t r_r;
    state_t r_nxt;

    // True when a level has just moved to the given polarity
    function automatic logic toggled_to(input logic prev, input logic now,
                                        input logic pol);
        toggled_to = (prev != pol) && (now == pol);
    endfunction : toggled_to

    logic [DIV_W-1:0] divisor;
    logic [1:0] pll_sel;
    logic [1:0] wake_idx;
    logic wake_lvl;
    logic wake_hit;
    logic target;
    logic sleep_req;
    logic pll_out;
    logic cur_lvl;
    logic new_lvl;
    logic div_err;

    always_comb begin
        divisor = r_r.ctl[CTL_DIV_LO +: DIV_W];
        pll_sel = r_r.ctl[CTL_PLL_SEL_LO +: 2];
        wake_idx = r_r.ctl[CTL_WAKE_SRC_LO +: 2];
        wake_lvl = i_wake_src[wake_idx];
        wake_hit = toggled_to(r_r.wake_q, wake_lvl, r_r.ctl[CTL_WAKE_POL]);
        target = r_r.ctl[CTL_SYS_SEL];
        sleep_req = r_r.ctl[CTL_STOP_XTAL] && r_r.ctl[CTL_VCO_HALT_CTL] && target;
        div_err = (divisor < DIV_MIN) || (divisor > DIV_MAX);
        unique case (pll_out_sel_t'(pll_sel))
            PLL_OUT_VCO: pll_out = r_r.vco_q;
            PLL_OUT_DIV2: pll_out = r_r.div2;
            PLL_OUT_DIV4: pll_out = r_r.div4;
            PLL_OUT_XTAL_X2: pll_out = r_r.x2_q;
        endcase
        cur_lvl = r_r.cur_sel ? pll_out : r_r.pin_q;
        new_lvl = target ? pll_out : r_r.pin_q;
    end

    always_comb begin
        r_nxt = r_r;
        r_nxt.wake_rst = 1'b0;
        r_nxt.pin_q = i_clock_input_pin;
        r_nxt.vco_q = i_vco_clk;
        r_nxt.x2_q = i_xtal_x2_clk;
        r_nxt.wake_q = wake_lvl;
        // Divide chain runs off sampled VCO edges
        if (toggled_to(r_r.vco_q, i_vco_clk, 1'b1)) begin
            r_nxt.div2 = ~r_r.div2;
        end
        r_nxt.div2_q = r_r.div2;
        if (toggled_to(r_r.div2_q, r_r.div2, 1'b1)) begin
            r_nxt.div4 = ~r_r.div4;
        end

        // Write channels, address and data in either order
        if (i_s_axi_awvalid && o_s_axi_awready) begin
            r_nxt.aw_got = 1'b1;
            r_nxt.awaddr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && o_s_axi_wready) begin
            r_nxt.w_got = 1'b1;
            r_nxt.wdata = i_s_axi_wdata[CTL_W-1:0];
            r_nxt.wstrb = i_s_axi_wstrb[CTL_LANES-1:0];
        end
        if (r_r.aw_got && r_r.w_got) begin
            r_nxt.aw_got = 1'b0;
            r_nxt.w_got = 1'b0;
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp = RESP_OKAY;
            if (r_r.awaddr == CTL_OFFS) begin
                // Accepted in any state, the switch logic follows on its own
                for (int b = 0; b < CTL_LANES; b++) begin
                    if (r_r.wstrb[b]) begin
                        r_nxt.ctl[b*BYTE_W +: BYTE_W] = r_r.wdata[b*BYTE_W +: BYTE_W];
                    end
                end
            end else if (r_r.awaddr != STAT_OFFS) begin
                r_nxt.bresp = RESP_SLVERR;
            end
        end
        if (r_r.bvalid && i_s_axi_bready) begin
            r_nxt.bvalid = 1'b0;
        end

        // Read channel
        if (i_s_axi_arvalid && o_s_axi_arready) begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rdata = '0;
            r_nxt.rresp = RESP_OKAY;
            if (i_s_axi_araddr == CTL_OFFS) begin
                r_nxt.rdata[CTL_W-1:0] = r_r.ctl;
            end else if (i_s_axi_araddr == STAT_OFFS) begin
                r_nxt.rdata[STAT_CUR_SEL] = r_r.cur_sel;
                r_nxt.rdata[STAT_SWITCHING] = (r_r.st != SW_RUN);
                r_nxt.rdata[STAT_SLEEP] = (r_r.st == SW_SLEEP);
                r_nxt.rdata[STAT_SETTLED] = r_r.settled;
                r_nxt.rdata[STAT_DIV_ERR] = div_err;
            end else begin
                r_nxt.rresp = RESP_SLVERR;
            end
        end
        if (r_r.rvalid && i_s_axi_rready) begin
            r_nxt.rvalid = 1'b0;
        end

        // Settling timer only advises software, selection is never held off
        if (r_r.ctl[CTL_VCO_HALT_CTL]) begin
            r_nxt.settle_cnt = '0;
            r_nxt.settled = 1'b0;
        end else if (r_r.settle_cnt == SETTLE_W'(PLL_SETTLE_CYC - 1)) begin
            r_nxt.settled = 1'b1;
        end else begin
            r_nxt.settle_cnt = r_r.settle_cnt + 1'b1;
        end

        // Gate off only while the old source is low, reopen only while the
        // new one is low, so the core never sees a shortened phase
        unique case (r_r.st)
            SW_RUN: begin
                if (sleep_req || (target != r_r.cur_sel)) begin
                    r_nxt.st = SW_OFF;
                end
            end
            SW_OFF: begin
                if (!cur_lvl) begin
                    r_nxt.gated = 1'b1;
                    r_nxt.st = sleep_req ? SW_SLEEP : SW_ON;
                end
            end
            SW_ON: begin
                if (sleep_req) begin
                    r_nxt.st = SW_SLEEP;
                end else if (!new_lvl) begin
                    r_nxt.cur_sel = target;
                    r_nxt.gated = 1'b0;
                    r_nxt.st = SW_RUN;
                end
            end
            SW_SLEEP: begin
                if (wake_hit) begin
                    r_nxt.ctl = CTL_RESET;
                    r_nxt.wake_rst = 1'b1;
                    r_nxt.st = SW_ON;
                end else if (!sleep_req) begin
                    r_nxt.st = SW_ON;
                end
            end
        endcase
        r_nxt.core_clk = ~r_r.gated & cur_lvl;
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r_r <= STATE_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign o_s_axi_awready = ~r_r.aw_got & ~r_r.bvalid;
    assign o_s_axi_wready = ~r_r.w_got & ~r_r.bvalid;
    assign o_s_axi_bvalid = r_r.bvalid;
    assign o_s_axi_bresp = r_r.bresp;
    assign o_s_axi_arready = ~r_r.rvalid;
    assign o_s_axi_rvalid = r_r.rvalid;
    assign o_s_axi_rdata = r_r.rdata;
    assign o_s_axi_rresp = r_r.rresp;

    assign o_core_clk = r_r.core_clk;
    assign o_xtal_run = ~r_r.ctl[CTL_STOP_XTAL];
    assign o_vco_run = ~r_r.ctl[CTL_VCO_HALT_CTL];
    assign o_pll_feed_xtal = r_r.cur_sel;
    assign o_vco_mult = VCO_MULT_W'(divisor) << VCO_MULT_SHIFT;
    assign o_pll_out_sel = pll_sel;
    assign o_wake_reset = r_r.wake_rst;
    assign o_clk_switching = (r_r.st != SW_RUN);
endmodule : system_clock_mode_control

// file: clock_source_model.sv
// Clock pin source and oscillator outputs seen by the block
module clock_source_model (
    input wire logic i_clk,
    input wire logic i_vco_on,
    output logic o_pin,
    output logic o_vco,
    output logic o_x2
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_r = 3'h0;
    // Crystal or user clock keeps the pin toggling, far slower than the core
    assign o_pin = cnt_r[2];
    // Stopped VCO is a flat line, never a stale clock
    assign o_vco = i_vco_on & cnt_r[0];
    assign o_x2 = cnt_r[1];
    always @(posedge i_clk) cnt_r <= cnt_r + 3'h1;
endmodule : clock_source_model

// file: system_clock_mode_control_properties.sv
// Port assertions for the clock mode block
module clock_mode_checker (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_s_axi_awvalid,
    input wire logic o_s_axi_awready,
    input wire logic i_s_axi_wvalid,
    input wire logic o_s_axi_wready,
    input wire logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic o_core_clk,
    input wire logic o_xtal_run,
    input wire logic o_vco_run,
    input wire logic o_pll_feed_xtal,
    input wire logic o_wake_reset,
    input wire logic o_clk_switching
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_wr;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
    endsequence
    property p_wr; s_wr |-> ##[1:2] o_s_axi_bvalid; endproperty
    a_wr: assert property (p_wr) else $error("no bvalid");
    property p_bh; o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid; endproperty
    a_bh: assert property (p_bh) else $error("bvalid drop");
    property p_rd; i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("no rvalid");
    property p_rh; o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid; endproperty
    a_rh: assert property (p_rh) else $error("rvalid drop");
    property p_rst; $rose(i_resetn) |-> o_xtal_run && o_vco_run; endproperty
    a_rst: assert property (p_rst) else $error("osc off at reset");
    // Deep sleep may be entered straight from PLL mode, so only the handover is checked
    property p_pll; $rose(o_pll_feed_xtal) |-> o_xtal_run && o_vco_run; endproperty
    a_pll: assert property (p_pll) else $error("pll osc off");
    property p_wk; o_wake_reset |=> !o_wake_reset && o_xtal_run && o_vco_run; endproperty
    a_wk: assert property (p_wk) else $error("bad wake");
    property p_sw; $fell(o_clk_switching) |-> !o_core_clk; endproperty
    a_sw: assert property (p_sw) else $error("runt at switch");
endmodule : clock_mode_checker

bind system_clock_mode_control clock_mode_checker u_chk (.*);

// file: testbench.sv
// Bench for the clock mode block
module testbench
    import clock_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk, i_resetn, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
    logic i_s_axi_arvalid, i_s_axi_rready, o_s_axi_awready, o_s_axi_wready;
    logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_core_clk, o_xtal_run;
    logic o_vco_run, o_pll_feed_xtal, o_wake_reset, o_clk_switching;
    logic i_clock_input_pin, i_vco_clk, i_xtal_x2_clk;
    logic [3:0] i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wstrb, i_wake_src;
    logic [31:0] i_s_axi_wdata, o_s_axi_rdata, d;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp, o_pll_out_sel;
    logic [VCO_MULT_W-1:0] o_vco_mult;
    logic [31:0] modes [3] = '{32'h0103, 32'h0102, 32'h0100};
    int mismatches, checked, cycles;
    int edges;
    logic core_q;
    system_clock_mode_control #(.PLL_SETTLE_CYC(20)) dut (.*);
    clock_source_model u_src (.i_clk(i_sys_clk), .i_vco_on(o_vco_run),
        .o_pin(i_clock_input_pin), .o_vco(i_vco_clk), .o_x2(i_xtal_x2_clk));
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
        input logic [1:0] er);
        @(posedge i_sys_clk);
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h7;
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= v;
        i_s_axi_wstrb <= s;
        do begin
            @(posedge i_sys_clk);
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
        end while (!o_s_axi_bvalid);
        i_s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, o_s_axi_bresp});
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge i_sys_clk);
        {i_s_axi_arvalid, i_s_axi_rready} <= 2'h3;
        i_s_axi_araddr <= a;
        do begin
            @(posedge i_sys_clk);
            if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
        end while (!o_s_axi_rvalid);
        i_s_axi_rready <= 1'b0;
        d = o_s_axi_rdata;
        chk("rdata", e, d & m);
    endtask : rd
    // Switch starts one edge after the write lands
    task automatic sw_wait;
        @(posedge i_sys_clk);
        while (o_clk_switching !== 1'b0) @(posedge i_sys_clk);
    endtask : sw_wait
    task automatic finish_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    initial begin
        i_resetn = 1'b0;
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready,
            i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wstrb, i_wake_src, i_s_axi_wdata} = '0;
        repeat (3) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        rd(CTL_OFFS, 32'h0100, '1);
        chk("run", 32'h3, {30'h0, o_vco_run, o_xtal_run});
        foreach (modes[i]) begin
            wr(CTL_OFFS, modes[i], 4'h3, RESP_OKAY);
            chk("run", {30'h0, ~modes[i][1:0]}, {30'h0, o_vco_run, o_xtal_run});
        end
        $display("modes done");
        // Settling time is software's duty, the block does not hold it off
        repeat (22) @(posedge i_sys_clk);
        wr(CTL_OFFS, 32'h0104, 4'h3, RESP_OKAY);
        sw_wait();
        chk("feed", 32'h1, {31'h0, o_pll_feed_xtal});
        wr(CTL_OFFS, 32'h0100, 4'h3, RESP_OKAY);
        sw_wait();
        chk("feed", 32'h0, {31'h0, o_pll_feed_xtal});
        for (int s = 0; s < 4; s++) begin
            wr(CTL_OFFS, 32'h9c00 | (s << 3), 4'h3, RESP_OKAY);
            chk("out_sel", s, {30'h0, o_pll_out_sel});
        end
        chk("mult", 32'h270, {22'h0, o_vco_mult});
        // Divided VCO of the model has a 4-cycle period, the pin an 8-cycle one
        wr(CTL_OFFS, 32'h9c0c, 4'h3, RESP_OKAY);
        sw_wait();
        edges = 0;
        core_q = o_core_clk;
        repeat (32) begin
            @(posedge i_sys_clk);
            if (o_core_clk && !core_q) edges++;
            core_q = o_core_clk;
        end
        chk("core_edges", 32'h8, edges);
        wr(CTL_OFFS, 32'h9c18, 4'h3, RESP_OKAY);
        sw_wait();
        wr(CTL_OFFS, 32'h2100, 4'h2, RESP_OKAY);
        rd(CTL_OFFS, 32'h2118, '1);
        chk("mult", 32'h84, {22'h0, o_vco_mult});
        wr(4'h8, 32'h0103, 4'h3, RESP_SLVERR);
        rd(CTL_OFFS, 32'h2118, '1);
        $display("pll done");
        wr(CTL_OFFS, 32'h0187, 4'h3, RESP_OKAY);
        do rd(STAT_OFFS, 32'h0, 32'hffffffe0); while (d[STAT_SLEEP] !== 1'b1);
        repeat (8) begin
            @(posedge i_sys_clk);
            chk("core", 32'h0, {31'h0, o_core_clk});
        end
        chk("run", 32'h0, {30'h0, o_vco_run, o_xtal_run});
        i_wake_src <= 4'h1;
        while (o_wake_reset !== 1'b1) @(posedge i_sys_clk);
        rd(CTL_OFFS, 32'h0100, '1);
        sw_wait();
        rd(STAT_OFFS, 32'h0, 32'h7);
        $display("sleep done");
        finish_test();
    end
endmodule : testbench
